// *** dac_code_word_loader_test.sv ***
// Self-checking bench for the DAC code word loader
`timescale 1ns/1ps
module dac_code_word_loader_test;
  logic mclk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic scl, m_oe, d_oe, sda, pd, sda_lvl;
  logic [9:0] code;
  logic [15:0] word;
  logic [15:0] tbl [4] = '{16'h3FA0, 16'h7FAF, 16'hC00F, 16'h0010};
  int n_errors = 0;
  int comparisons = 0;
  assign sda = ~(m_oe | d_oe);
  always #10 mclk_i = ~mclk_i;
  dcl_loader i_dcl_loader (.mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_lvl),
    .sda_oe_o(d_oe), .soft_power_down_bit_o(pd), .converter_code_bits_o(code), .input_word_o(word));
  dcl_master_model i_dcl_master_model (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_dac(input logic [15:0] w);
    chk("dac", {5'h00, w[15], w[13:4]}, {5'h00, pd, code});
  endtask : chk_dac
  task automatic wr(input logic [7:0] a, input logic [15:0] w, input int nb);
    logic [7:0] rx;
    logic ack;
    i_dcl_master_model.start();
    i_dcl_master_model.byte_io(a, 1'h1, rx, ack);
    chk("addr ack", {15'h0000, a[7:3] != 5'h03}, {15'h0000, ack});
    for (int i = 0; i < nb; i++) begin
      i_dcl_master_model.byte_io(w[15 - 8 * i -: 8], 1'h1, rx, ack);
      chk("data ack", 16'h0000, {15'h0000, ack});
    end
    i_dcl_master_model.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [7:0] hi, lo;
    logic ack;
    i_dcl_master_model.start();
    i_dcl_master_model.byte_io(a, 1'h1, hi, ack);
    chk("addr ack", 16'h0000, {15'h0000, ack});
    i_dcl_master_model.byte_io(8'hFF, 1'h0, hi, ack);
    i_dcl_master_model.byte_io(8'hFF, 1'h1, lo, ack);
    i_dcl_master_model.stop();
    chk("read word", exp, {hi, lo});
    chk("cleared", 16'h0000, word);
  endtask : rd
  task automatic rd_hi(input logic [7:0] a, input logic [15:0] w);
    logic [7:0] hi;
    logic ack;
    i_dcl_master_model.start();
    i_dcl_master_model.byte_io(a, 1'h1, hi, ack);
    chk("addr ack", 16'h0000, {15'h0000, ack});
    i_dcl_master_model.byte_io(8'hFF, 1'h1, hi, ack);
    i_dcl_master_model.stop();
    chk("read hi", {8'h00, w[15:8]}, {8'h00, hi});
    chk("kept", w, word);
  endtask : rd_hi
  task automatic stop_test();
    $display("Comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #300us;
    n_errors++;
    $display("Error watchdog expected done seen hang");
    stop_test();
  end
  initial begin
    repeat (16) @(negedge mclk_i);
    nrst_i = 1'h1;
    repeat (4) @(negedge mclk_i);
    chk("reset word", 16'h0000, word);
    chk_dac(16'h0000);
    chk("drive level", 16'h0000, {15'h0000, sda_lvl});
    $display("Test reset done");
    // Every address alias, ignored bits toggled
    for (int i = 0; i < 4; i++) begin
      wr(8'h18 + 8'(2 * i), tbl[i], 2);
      chk("word", tbl[i], word);
      chk_dac(tbl[i]);
    end
    $display("Test write done");
    wr(8'h18, 16'hA5F0, 1);
    chk("word hi", 16'h00A5, {8'h00, word[15:8]});
    chk_dac(16'h0010);
    wr(8'h10, 16'hFFFF, 0);
    chk_dac(16'h0010);
    $display("Test short done");
    wr(8'h1A, 16'h5A5C, 2);
    rd(8'h1B, 16'h5A5C);
    rd(8'h1F, 16'h0000);
    chk_dac(16'h5A5C);
    wr(8'h1C, 16'h9C30, 2);
    rd_hi(8'h1D, 16'h9C30);
    chk_dac(16'h9C30);
    $display("Test read done");
    i_dcl_master_model.gap = 6;
    wr(8'h1E, 16'h8230, 2);
    chk_dac(16'h8230);
    i_dcl_master_model.gap = 0;
    $display("Test slow done");
    stop_test();
  end
endmodule : dac_code_word_loader_test

// *** dcl_bus_sync.sv ***
// Two-stage synchroniser and edge / condition detector for the serial bus pins
`timescale 1ns/1ps
module dcl_bus_sync (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output dcl_pkg::dcl_ev_t ev_o
);
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  wire scl_rise = scl_sync_reg[1] & ~scl_d_reg;
  wire scl_fall = ~scl_sync_reg[1] & scl_d_reg;
  wire bus_start = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
  wire bus_stop = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];

  assign sda_o = sda_sync_reg[1];
  assign ev_o = '{start: bus_start, stop: bus_stop, rise: scl_rise, fall: scl_fall};
endmodule : dcl_bus_sync

// *** dcl_loader.sv ***
// Serial bus slave that loads the input word and moves it to the DAC register
// Summary of operation
// - Two bytes, upper first, MSB first
// - Serial bits collect in sixteen-bit input word
// - DAC register loads only after whole word
// - Word bit 15 requests power-down when one
// - Word bits 13..4 give code bits 9..0
// - Word bit 14 and bits 3..0 ignored
// - Reads return word, upper byte first then lower byte, MSB first
// - Input word cleared after a two-byte read; kept after a one-byte read
// - Address 0001100, low two bits don't-care
// - Acknowledge address and both data bytes
`timescale 1ns/1ps
module dcl_loader (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic soft_power_down_bit_o,
  output logic [9:0] converter_code_bits_o,
  output logic [15:0] input_word_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK} dcl_state_t;

  dcl_pkg::dcl_ev_t ev;
  logic sda_s;
  dcl_state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic byte_idx_reg, byte_idx_next;
  logic rw_reg, rw_next;
  logic [15:0] word_reg, word_next;
  dcl_pkg::dcl_dac_t dac_reg, dac_next;
  logic oe_reg, oe_next;
  logic rd_done_reg, rd_done_next;

  dcl_bus_sync i_dcl_bus_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_s),
    .ev_o(ev)
  );

  wire addr_match = (shift_reg[7:3] == dcl_pkg::DEV_ADDR_HI);
  wire byte_full = (bit_cnt_reg == 4'h8);
  wire [7:0] rd_byte = byte_idx_reg ? word_reg[7:0] : word_reg[15:8];
  wire [2:0] rd_bit_idx = 3'h7 - bit_cnt_reg[2:0];
  wire [15:0] full_word = {word_reg[15:8], shift_reg};

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_idx_next = byte_idx_reg;
    rw_next = rw_reg;
    word_next = word_reg;
    dac_next = dac_reg;
    oe_next = oe_reg;
    rd_done_next = rd_done_reg;
    if (ev.start) begin
      state_next = ST_ADDR;
      bit_cnt_next = 4'h0;
      byte_idx_next = 1'b0;
      oe_next = 1'b0;
      if (rd_done_reg) begin
        word_next = dcl_pkg::WORD_RST;
      end
      rd_done_next = 1'b0;
    end else if (ev.stop) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
      if (rd_done_reg) begin
        word_next = dcl_pkg::WORD_RST;
      end
      rd_done_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          oe_next = 1'b0;
        end
        ST_ADDR: begin
          if (ev.rise && !byte_full) begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (ev.fall && byte_full) begin
            if (addr_match) begin
              oe_next = 1'b1;
              rw_next = shift_reg[0];
              state_next = ST_ADDR_ACK;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (ev.fall) begin
            bit_cnt_next = 4'h0;
            if (rw_reg) begin
              oe_next = ~rd_byte[3'h7];
              state_next = ST_RDATA;
            end else begin
              oe_next = 1'b0;
              state_next = ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (ev.rise && !byte_full) begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (ev.fall && byte_full) begin
            oe_next = 1'b1;
            state_next = ST_WACK;
            if (!byte_idx_reg) begin
              word_next = {shift_reg, word_reg[7:0]};
            end else begin
              word_next = full_word;
              dac_next.pd = full_word[dcl_pkg::PD_POS];
              dac_next.code = full_word[dcl_pkg::CODE_MSB_POS:dcl_pkg::CODE_LSB_POS];
            end
          end
        end
        ST_WACK: begin
          if (ev.fall) begin
            oe_next = 1'b0;
            bit_cnt_next = 4'h0;
            byte_idx_next = ~byte_idx_reg;
            state_next = byte_idx_reg ? ST_IDLE : ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (ev.fall) begin
            if (bit_cnt_reg == 4'h7) begin
              oe_next = 1'b0;
              bit_cnt_next = 4'h0;
              state_next = ST_RACK;
            end else begin
              bit_cnt_next = bit_cnt_reg + 4'h1;
              oe_next = ~rd_byte[rd_bit_idx - 3'h1];
            end
          end
        end
        ST_RACK: begin
          if (ev.rise) begin
            if (byte_idx_reg) begin
              rd_done_next = 1'b1;
              state_next = ST_IDLE;
            end else if (sda_s) begin
              state_next = ST_IDLE;
            end
          end else if (ev.fall) begin
            byte_idx_next = 1'b1;
            oe_next = ~word_reg[7];
            state_next = ST_RDATA;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 1'b0;
      rw_reg <= 1'b0;
      word_reg <= dcl_pkg::WORD_RST;
      dac_reg <= '{pd: dcl_pkg::PD_RST, code: dcl_pkg::CODE_RST};
      oe_reg <= 1'b0;
      rd_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_idx_reg <= byte_idx_next;
      rw_reg <= rw_next;
      word_reg <= word_next;
      dac_reg <= dac_next;
      oe_reg <= oe_next;
      rd_done_reg <= rd_done_next;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_reg;
  assign soft_power_down_bit_o = dac_reg.pd;
  assign converter_code_bits_o = dac_reg.code;
  assign input_word_o = word_reg;

  property p_dac_only_on_second_byte;
    @(posedge mclk_i) disable iff (!nrst_i)
      (dac_reg != $past(dac_reg)) |-> ($past(state_reg) == ST_WDATA && $past(byte_idx_reg));
  endproperty
  a_dac_only_on_second_byte: assert property (p_dac_only_on_second_byte) else $error("DAC changed early");

  property p_dac_map;
    @(posedge mclk_i) disable iff (!nrst_i)
      ($past(state_reg) == ST_WDATA && $past(byte_idx_reg) && state_reg == ST_WACK) |->
        (dac_reg.code == {$past(word_reg[13:8]), $past(shift_reg[7:4])} && dac_reg.pd == $past(word_reg[15]));
  endproperty
  a_dac_map: assert property (p_dac_map) else $error("DAC field mapping wrong");

  property p_read_clear;
    @(posedge mclk_i) disable iff (!nrst_i)
      (rd_done_reg && (ev.stop || ev.start)) |=> (word_reg == dcl_pkg::WORD_RST);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("Input word not cleared after read");

  property p_addr_ack;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_reg == ST_ADDR && byte_full && ev.fall && !ev.start && !ev.stop && addr_match) |=> sda_oe_o;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("Address not acknowledged");

  property p_no_ack_foreign;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_reg == ST_ADDR && byte_full && ev.fall && !ev.start && !ev.stop && !addr_match) |=> state_reg == ST_IDLE;
  endproperty
  a_no_ack_foreign: assert property (p_no_ack_foreign) else $error("Foreign address accepted");

  property p_data_ack;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_reg == ST_WACK) |-> sda_oe_o;
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("Data byte not acknowledged");

  property p_shift_msb_first;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_reg == ST_WDATA && ev.rise && !byte_full && !ev.start && !ev.stop) |=>
        (shift_reg[0] == $past(sda_s) && shift_reg[7:1] == $past(shift_reg[6:0]));
  endproperty
  a_shift_msb_first: assert property (p_shift_msb_first) else $error("Shift order wrong");

  property p_read_first_bit;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_reg == ST_ADDR_ACK && rw_reg && ev.fall && !ev.start && !ev.stop) |=> (sda_oe_o == ~word_reg[15]);
  endproperty
  a_read_first_bit: assert property (p_read_first_bit) else $error("Read MSB wrong");
endmodule : dcl_loader

// *** dcl_master_model.sv ***
// Serial bus master model that drives the clock and pulls the data line
`timescale 1ns/1ps
module dcl_master_model (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  int gap = 0;
  initial begin
    scl_o = 1'h1;
    sda_oe_o = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick
  task automatic start();
    tick(2 + gap);
    sda_oe_o = 1'h0;
    tick(2);
    scl_o = 1'h1;
    tick(4);
    sda_oe_o = 1'h1;
    tick(4);
    scl_o = 1'h0;
  endtask : start
  task automatic stop();
    tick(2 + gap);
    sda_oe_o = 1'h1;
    tick(2);
    scl_o = 1'h1;
    tick(4);
    sda_oe_o = 1'h0;
    tick(4);
  endtask : stop
  task automatic bit_io(input logic tx, output logic rx);
    tick(2 + gap);
    sda_oe_o = ~tx;
    tick(2);
    scl_o = 1'h1;
    tick(4);
    rx = sda_i;
    scl_o = 1'h0;
  endtask : bit_io
  task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack);
  endtask : byte_io
endmodule : dcl_master_model

// *** dcl_pkg.sv ***
// Package of constants and types for the DAC code word loader
package dcl_pkg;
  localparam logic [4:0] DEV_ADDR_HI = 5'h03;
  localparam int ADDR_DC_BITS = 2;
  localparam int WORD_W = 16;
  localparam int CODE_W = 10;
  localparam int PD_POS = 15;
  localparam int UNUSED_HI_POS = 14;
  localparam int CODE_MSB_POS = 13;
  localparam int CODE_LSB_POS = 4;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [9:0] CODE_RST = 10'h000;
  localparam logic PD_RST = 1'b0;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic pd;
    logic [9:0] code;
  } dcl_dac_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } dcl_ev_t;
endpackage : dcl_pkg
